/* mbp_port.sv */
// multiplexed address/data host port, open-drain interrupt request,
// key wake and system power-on control, with an avalon-mm control slave
// assumes the clock core beyond it answers reads combinationally on core_rdata_i
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps

// Behaviour
// [R1] without main supply, key wake or wake-up interrupt turns system power on
// [R2] with supply present, software sets the power-on output through a control bit
// [R3] without main supply, a falling key wake edge starts system power-on
// [R4] software must set aux battery enable before relying on key wake power-on
// [R5] with main supply present, key wake edges raise an interrupt instead
// [R6] host drives device select low for any register access
// [R7] host keeps device select low for the whole read or write strobe
// [R8] latch strobe with device deselected captures the address but moves no data
// [R9] register address is captured on the falling edge of the latch strobe
// [R10] register write happens only within an asserted write strobe
// [R11] read data is driven only while the read strobe is low
// [R12] supply select high means five volt mode
// [R13] supply select low or floating means autosense mode
// [R14] interrupt pin held low while any enabled status flag is set
// [R15] software clears all enabled contributing flags to release the interrupt pin
// [R16] interrupt pin is released, never driven high, when nothing is pending
// [R17] host keeps write data stable through the late part of the write strobe
// [R18] read drives eight bits late in the strobe and releases when it rises
// [R19] strobes, bus and key wake are synchronised before any logic uses them
module mbp_port (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [mbp_pkg::AVS_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [mbp_pkg::AVS_DW-1:0] avs_writedata_i,
  output logic [mbp_pkg::AVS_DW-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  input wire logic ale_i,
  input wire logic dev_sel_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [mbp_pkg::DATA_W-1:0] muxed_addr_data_bus_i,
  output logic [mbp_pkg::DATA_W-1:0] muxed_addr_data_bus_o,
  output logic muxed_addr_data_bus_oe_o,
  output logic irq_n_o,
  output logic irq_n_oe_o,
  input wire logic key_wake_input_n_i,
  input wire logic main_supply_ok_i,
  input wire logic supply_sel_i,
  output logic system_power_on_n_o,
  output logic five_volt_mode_o,
  output logic autosense_mode_o,
  output mbp_pkg::mbp_core_wr_t core_wr_o,
  input wire logic [mbp_pkg::DATA_W-1:0] core_rdata_i,
  input wire logic core_wake_irq_i
);

  // ==========================================================================
  // pin synchronisers
  // s1 feeds only s2; edges compare s2 against s3
  mbp_pkg::mbp_pins_t pins_raw;
  mbp_pkg::mbp_pins_t s1_r;
  mbp_pkg::mbp_pins_t s2_r;
  mbp_pkg::mbp_pins_t s3_r;

  assign pins_raw = '{ale: ale_i, cs_n: dev_sel_n_i, rd_n: rd_n_i, wr_n: wr_n_i,
                      key_n: key_wake_input_n_i, supply_ok: main_supply_ok_i,
                      psel: supply_sel_i, data: muxed_addr_data_bus_i};

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_r <= mbp_pkg::PINS_RST;
      s2_r <= mbp_pkg::PINS_RST;
      s3_r <= mbp_pkg::PINS_RST;
    end else begin
      s1_r <= pins_raw; // R19
      s2_r <= s1_r; // R19
      s3_r <= s2_r;
    end
  end

  logic ale_fall;
  logic key_fall;
  logic supply_ok;
  assign ale_fall = s3_r.ale & ~s2_r.ale;
  assign key_fall = s3_r.key_n & ~s2_r.key_n;
  assign supply_ok = s2_r.supply_ok;

  // ==========================================================================
  // avalon slave: one wait cycle, then the access is taken
  logic wait_r;
  logic wait_nxt;
  logic [mbp_pkg::AVS_DW-1:0] rdata_r;
  logic [mbp_pkg::AVS_DW-1:0] rdata_nxt;
  logic [mbp_pkg::CTRL_W-1:0] ctrl_r;
  logic [mbp_pkg::CTRL_W-1:0] ctrl_nxt;
  logic [mbp_pkg::NEV-1:0] stat_r;
  logic [mbp_pkg::NEV-1:0] stat_nxt;
  logic [mbp_pkg::NEV-1:0] mask_r;
  logic [mbp_pkg::NEV-1:0] mask_nxt;
  logic [mbp_pkg::NEV-1:0] ev_set;
  logic [mbp_pkg::NEV-1:0] ev_clr;
  logic wr_take;
  logic ctrl_wr;
  logic pwr_n_r;
  logic pwr_n_nxt;
  logic [mbp_pkg::DATA_W-1:0] addr_r;
  logic [mbp_pkg::DATA_W-1:0] addr_nxt;

  assign wr_take = avs_write_i & ~wait_r;
  assign ctrl_wr = wr_take & (avs_address_i == mbp_pkg::OFF_CTRL);

  always_comb begin
    wait_nxt = ~((avs_read_i | avs_write_i) & wait_r);
    rdata_nxt = rdata_r;
    if (avs_read_i & wait_r) begin
      case (avs_address_i)
        mbp_pkg::OFF_CTRL: rdata_nxt = {{(mbp_pkg::AVS_DW-mbp_pkg::CTRL_W){1'b0}}, ctrl_r};
        mbp_pkg::OFF_STAT: rdata_nxt = {{(mbp_pkg::AVS_DW-mbp_pkg::NEV){1'b0}}, stat_r};
        mbp_pkg::OFF_MASK: rdata_nxt = {{(mbp_pkg::AVS_DW-mbp_pkg::NEV){1'b0}}, mask_r};
        mbp_pkg::OFF_STATE: begin
          rdata_nxt = 32'h0000_0000;
          rdata_nxt[mbp_pkg::ST_SUPPLY_BIT] = supply_ok;
          rdata_nxt[mbp_pkg::ST_5V_BIT] = five_volt_mode_o;
          rdata_nxt[mbp_pkg::ST_PWR_BIT] = ~pwr_n_r;
          rdata_nxt[mbp_pkg::ST_KEY_BIT] = s2_r.key_n;
          rdata_nxt[mbp_pkg::ST_ADDR_LSB +: mbp_pkg::DATA_W] = addr_r;
        end
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    ctrl_nxt = ctrl_wr ? avs_writedata_i[mbp_pkg::CTRL_W-1:0] : ctrl_r;
    mask_nxt = (wr_take && avs_address_i == mbp_pkg::OFF_MASK) ?
               avs_writedata_i[mbp_pkg::NEV-1:0] : mask_r;
    ev_clr = (wr_take && avs_address_i == mbp_pkg::OFF_STAT) ?
             avs_writedata_i[mbp_pkg::NEV-1:0] : '0;
    // a set in the clearing cycle wins so no event is lost
    stat_nxt = (stat_r & ~ev_clr) | ev_set;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      ctrl_r <= mbp_pkg::CTRL_RST;
      mask_r <= mbp_pkg::EV_RST;
      stat_r <= mbp_pkg::EV_RST;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
      stat_r <= stat_nxt;
    end
  end

  // ==========================================================================
  // host bus cycle
  mbp_pkg::mbp_bus_st_t bus_st_r;
  mbp_pkg::mbp_bus_st_t bus_st_nxt;
  logic [mbp_pkg::DATA_W-1:0] wdata_r;
  logic [mbp_pkg::DATA_W-1:0] wdata_nxt;
  logic sel_ok_r;
  logic sel_ok_nxt;
  logic we_r;
  logic we_nxt;
  logic oe_r;
  logic oe_nxt;
  logic [mbp_pkg::DATA_W-1:0] dout_r;
  logic [mbp_pkg::DATA_W-1:0] dout_nxt;
  logic rd_done;

  always_comb begin
    bus_st_nxt = bus_st_r;
    wdata_nxt = wdata_r;
    sel_ok_nxt = sel_ok_r;
    we_nxt = 1'b0;
    oe_nxt = 1'b0;
    dout_nxt = dout_r;
    rd_done = 1'b0;
    // address is taken whether or not the device is selected
    addr_nxt = ale_fall ? s3_r.data : addr_r; // R9 R8
    case (bus_st_r)
      mbp_pkg::BUS_IDLE: begin
        sel_ok_nxt = 1'b1;
        if (!s2_r.cs_n && !s2_r.wr_n) begin
          bus_st_nxt = mbp_pkg::BUS_WR;
        end else if (!s2_r.cs_n && !s2_r.rd_n) begin
          bus_st_nxt = mbp_pkg::BUS_RD;
        end
      end
      mbp_pkg::BUS_WR: begin
        // keep the latest sample so the late part of the strobe decides
        if (!s2_r.wr_n) begin
          wdata_nxt = s2_r.data; // R10
        end
        // a select that drops mid strobe voids the write
        if (s2_r.cs_n) begin
          sel_ok_nxt = 1'b0; // R7
        end
        if (s2_r.wr_n) begin
          we_nxt = sel_ok_r & ~s2_r.cs_n; // R10
          bus_st_nxt = mbp_pkg::BUS_IDLE;
        end
      end
      mbp_pkg::BUS_RD: begin
        if (s2_r.rd_n || s2_r.cs_n) begin
          rd_done = 1'b1;
          bus_st_nxt = mbp_pkg::BUS_IDLE; // R18
        end else begin
          oe_nxt = 1'b1; // R11
          dout_nxt = core_rdata_i; // R18
        end
      end
      default: bus_st_nxt = mbp_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_st_r <= mbp_pkg::BUS_IDLE;
      wdata_r <= 8'h00;
      addr_r <= 8'h00;
      sel_ok_r <= 1'b1;
      we_r <= 1'b0;
      oe_r <= 1'b0;
      dout_r <= 8'h00;
    end else begin
      bus_st_r <= bus_st_nxt;
      wdata_r <= wdata_nxt;
      addr_r <= addr_nxt;
      sel_ok_r <= sel_ok_nxt;
      we_r <= we_nxt;
      oe_r <= oe_nxt;
      dout_r <= dout_nxt;
    end
  end

  // ==========================================================================
  // power-on control, events, interrupt pins, supply mode
  logic irq_r;
  logic irq_nxt;
  logic psel_r;
  logic auto_r;

  always_comb begin
    pwr_n_nxt = pwr_n_r;
    ev_set = '0;
    if (!supply_ok) begin
      // key wake needs the aux battery enabled, otherwise it is ignored
      if (key_fall && ctrl_r[mbp_pkg::CTRL_ABE_BIT]) begin
        pwr_n_nxt = 1'b0; // R3 R4
        ev_set[mbp_pkg::EV_WAKE] = 1'b1;
      end
      if (core_wake_irq_i) begin
        pwr_n_nxt = 1'b0; // R1
        ev_set[mbp_pkg::EV_WAKE] = 1'b1;
      end
    end else begin
      ev_set[mbp_pkg::EV_KEY] = key_fall; // R5
      if (ctrl_wr) begin
        pwr_n_nxt = ~avs_writedata_i[mbp_pkg::CTRL_PWR_BIT]; // R2
      end
    end
    ev_set[mbp_pkg::EV_WR] = we_r;
    ev_set[mbp_pkg::EV_RD] = rd_done;
    ev_set[mbp_pkg::EV_DESEL] = ale_fall & s2_r.cs_n; // R8
    irq_nxt = |(stat_r & mask_r); // R14 R16
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwr_n_r <= 1'b1;
      irq_r <= 1'b0;
      psel_r <= 1'b0;
      auto_r <= 1'b1;
    end else begin
      pwr_n_r <= pwr_n_nxt;
      irq_r <= irq_nxt;
      psel_r <= s2_r.psel; // R12 R13
      auto_r <= ~s2_r.psel; // R13
    end
  end

  // ==========================================================================
  // outputs
  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign irq_o = irq_r;
  assign muxed_addr_data_bus_o = dout_r;
  assign muxed_addr_data_bus_oe_o = oe_r;
  // open drain: the pin only ever pulls low, so the data side is a constant
  assign irq_n_o = 1'b0;
  assign irq_n_oe_o = irq_r;
  assign system_power_on_n_o = pwr_n_r;
  assign five_volt_mode_o = psel_r;
  assign autosense_mode_o = auto_r;
  assign core_wr_o = '{addr: addr_r, wdata: wdata_r, we: we_r};

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  a_addr_latch: assert property (ale_fall |=> addr_r == $past(s3_r.data)) // R9
    else $error("address not latched on strobe fall");
  a_desel_flag: assert property (ale_fall && s2_r.cs_n |=> stat_r[mbp_pkg::EV_DESEL]) // R8
    else $error("deselected latch strobe not flagged");
  a_write_window: assert property (we_r |-> $past(bus_st_r) == mbp_pkg::BUS_WR
                                   && $past(s2_r.wr_n) && !$past(s2_r.cs_n)) // R10
    else $error("core write outside a selected write strobe");
  a_read_gate: assert property (muxed_addr_data_bus_oe_o |->
                                !$past(s2_r.rd_n) && !$past(s2_r.cs_n)) // R11
    else $error("bus driven without read strobe");
  a_read_release: assert property (bus_st_r == mbp_pkg::BUS_RD && s2_r.rd_n
                                   |=> !muxed_addr_data_bus_oe_o ##1
                                   !muxed_addr_data_bus_oe_o) // R18
    else $error("bus not released after read strobe");
  a_read_data: assert property (muxed_addr_data_bus_oe_o |->
                                muxed_addr_data_bus_o == $past(core_rdata_i)) // R18
    else $error("read data does not match core");
  a_irq_assert: assert property (|(stat_r & mask_r) |=> irq_n_oe_o && !irq_n_o) // R14
    else $error("interrupt pin not pulled low");
  a_irq_release: assert property (!(|(stat_r & mask_r)) |=> !irq_n_oe_o) // R16
    else $error("interrupt pin driven with nothing pending");
  a_kick_power: assert property (!supply_ok && key_fall && ctrl_r[mbp_pkg::CTRL_ABE_BIT]
                                 |=> !system_power_on_n_o) // R3
    else $error("key wake did not power on");
  a_wake_power: assert property (!supply_ok && core_wake_irq_i |=> !system_power_on_n_o) // R1
    else $error("wake interrupt did not power on");
  a_key_irq: assert property (supply_ok && key_fall && !ctrl_wr
                              |=> stat_r[mbp_pkg::EV_KEY] && $stable(system_power_on_n_o)) // R5
    else $error("key wake with supply not an interrupt");
  a_sw_power: assert property (supply_ok && ctrl_wr |=> system_power_on_n_o ==
                               !$past(avs_writedata_i[mbp_pkg::CTRL_PWR_BIT])) // R2
    else $error("software power level not applied");
  a_supply_mode: assert property (##1 five_volt_mode_o == $past(s2_r.psel)
                                  && autosense_mode_o == !five_volt_mode_o) // R12
    else $error("supply mode does not follow select");

endmodule

/* mbp_pkg.sv */
// package for the multiplexed host bus port with interrupt and key wake logic
// assumes a single 125 MHz core clock; the pins arrive asynchronous to it
package mbp_pkg;

  // ==========================================================================
  // register map, avalon byte addresses
  localparam int AVS_AW = 4;
  localparam int AVS_DW = 32;
  localparam logic [AVS_AW-1:0] OFF_CTRL = 4'h0;
  localparam logic [AVS_AW-1:0] OFF_STAT = 4'h4;
  localparam logic [AVS_AW-1:0] OFF_MASK = 4'h8;
  localparam logic [AVS_AW-1:0] OFF_STATE = 4'hc;

  // ==========================================================================
  // field layout
  localparam int CTRL_W = 2;
  localparam int CTRL_ABE_BIT = 0;
  localparam int CTRL_PWR_BIT = 1;
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;

  localparam int NEV = 5;
  localparam int EV_KEY = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_WR = 2;
  localparam int EV_RD = 3;
  localparam int EV_DESEL = 4;
  localparam logic [NEV-1:0] EV_RST = 5'h00;

  localparam int ST_SUPPLY_BIT = 0;
  localparam int ST_5V_BIT = 1;
  localparam int ST_PWR_BIT = 2;
  localparam int ST_KEY_BIT = 3;
  localparam int ST_ADDR_LSB = 8;

  localparam int DATA_W = 8;

  // ==========================================================================
  // carriers and states
  typedef struct packed {
    logic ale;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic key_n;
    logic supply_ok;
    logic psel;
    logic [DATA_W-1:0] data;
  } mbp_pins_t;

  localparam mbp_pins_t PINS_RST = '{ale: 1'b0, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                     key_n: 1'b1, supply_ok: 1'b0, psel: 1'b0,
                                     data: 8'h00};

  typedef struct packed {
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
  } mbp_core_wr_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WR = 2'b01,
    BUS_RD = 2'b10
  } mbp_bus_st_t;

endpackage

/* mbp_host_model.sv */
// host processor model on the muxed address/data bus
// assumes xfer is called right after a rising clock edge
`timescale 1ns/1ps
module mbp_host_model (
  input wire logic clk_i,
  input wire logic [7:0] dev_d_i,
  input wire logic dev_oe_i,
  output logic ale_o,
  output logic sel_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [7:0] bus_o
);
  logic [7:0] hd = 8'h00;
  logic hdrv = 1'b0;
  // ==========================================
  // bus level
  // released bus shows the inverse, so a stale value never passes
  assign bus_o = dev_oe_i ? dev_d_i : (hdrv ? hd : ~hd);
  initial begin
    ale_o = 1'b0;
    sel_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
  end
  // ==========================================
  // one bus cycle, strobes kept long for the synchronisers
  task xfer(input logic r, input logic s, input logic [7:0] a, input logic [7:0] d,
            output logic [7:0] q);
    ale_o <= 1'b1;
    hd <= a;
    hdrv <= 1'b1;
    // select already low at the latch strobe, else the cycle counts as deselected
    sel_n_o <= !s;
    repeat (6) @(posedge clk_i);
    ale_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    hd <= d;
    hdrv <= !r;
    repeat (2) @(posedge clk_i);
    rd_n_o <= !r;
    wr_n_o <= r;
    repeat (8) @(posedge clk_i);
    q = bus_o;
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    sel_n_o <= 1'b1;
    hdrv <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
endmodule

/* mbp_port_tb.sv */
// testbench for the muxed host port with irq and key wake
// the bench stands in for the clock core and the avalon master
`timescale 1ns/1ps
module mbp_port_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] aa = 4'h0;
  logic ar = 1'b0;
  logic aw = 1'b0;
  logic key_n = 1'b1;
  logic sup = 1'b1;
  logic psel = 1'b0;
  logic wake = 1'b0;
  logic [31:0] awd = 32'h0;
  logic [31:0] aq;
  logic [31:0] q32;
  logic [7:0] crd = 8'h00;
  logic [7:0] bus, dq, hq, a, d;
  logic wt, irq, dvoe, irqn, irqoe, pwr_n, v5, auto_m, ale, sel_n, rd_n, wr_n;
  mbp_pkg::mbp_core_wr_t cw;
  logic [15:0] wq[$];
  logic [15:0] e;
  int err_total = 0;
  int check_count = 0;
  int seed = 82;

  always #4 clk = ~clk;

  mbp_port u_mbp_port (
    .core_clk_i(clk), .nrst_i(rst_n), .avs_address_i(aa), .avs_read_i(ar),
    .avs_write_i(aw), .avs_writedata_i(awd), .avs_readdata_o(aq),
    .avs_waitrequest_o(wt), .irq_o(irq), .ale_i(ale), .dev_sel_n_i(sel_n),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .muxed_addr_data_bus_i(bus),
    .muxed_addr_data_bus_o(dq), .muxed_addr_data_bus_oe_o(dvoe), .irq_n_o(irqn),
    .irq_n_oe_o(irqoe), .key_wake_input_n_i(key_n), .main_supply_ok_i(sup),
    .supply_sel_i(psel), .system_power_on_n_o(pwr_n), .five_volt_mode_o(v5),
    .autosense_mode_o(auto_m), .core_wr_o(cw), .core_rdata_i(crd),
    .core_wake_irq_i(wake));
  mbp_host_model u_mbp_host_model (
    .clk_i(clk), .dev_d_i(dq), .dev_oe_i(dvoe), .ale_o(ale), .sel_n_o(sel_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .bus_o(bus));

  // ==========================================
  // core stand-in and write monitor
  always @(posedge clk) begin
    crd <= cw.addr ^ 8'h5a;
    if (cw.we === 1'b1) begin
      if (wq.size() == 0) begin
        chk("stray we", 1, 0);
      end else begin
        e = wq.pop_front();
        chk("waddr", cw.addr, e[15:8]);
        chk("wdata", cw.wdata, e[7:0]);
      end
    end
  end

  // ==========================================
  // tasks
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", n, x, s);
    end
  endtask

  task results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // master holds the request until waitrequest is seen low
  task avs(input logic w, input logic [3:0] ad, input logic [31:0] wd);
    int n;
    aa <= ad;
    aw <= w;
    ar <= !w;
    awd <= wd;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (wt === 1'b0) break;
    end
    if (n == 40) begin
      chk("avs timeout", 1, 0);
      results();
    end
    q32 = aq;
    aw <= 1'b0;
    ar <= 1'b0;
    @(posedge clk);
  endtask

  task rdc(input string n, input logic [3:0] ad, input logic [31:0] x);
    avs(1'b0, ad, 32'h0);
    chk(n, q32, x);
  endtask

  task hop(input logic r, input logic s);
    a = $random(seed);
    d = $random(seed);
    if (!r && s) wq.push_back({a, d});
    u_mbp_host_model.xfer(r, s, a, d, hq);
  endtask

  task key();
    key_n <= 1'b0;
    tick(6);
    key_n <= 1'b1;
    tick(6);
  endtask

  // ==========================================
  // main sequence
  initial begin
    tick(4);
    rst_n <= 1'b1;
    tick(4);
    chk("oe idle", dvoe, 0);
    chk("irq idle", irqoe, 0);
    chk("auto", auto_m, 1);
    chk("five", v5, 0);
    chk("pwr idle", pwr_n, 1);
    rdc("ctrl", mbp_pkg::OFF_CTRL, 32'h0);
    rdc("unmapped", 4'h2, 32'h0);
    psel <= 1'b1;
    tick(6);
    chk("five", v5, 1);
    chk("auto", auto_m, 0);
    psel <= 1'b0;
    avs(1'b1, mbp_pkg::OFF_MASK, 32'h1f);
    for (int i = 0; i < 3; i++) begin
      hop(1'b0, 1'b1);
      avs(1'b0, mbp_pkg::OFF_STATE, 32'h0);
      chk("latched", q32[15:8], a);
      chk("irq on", irqoe, 1);
      chk("irq low", irqn, 0);
      chk("irq lvl", irq, 1);
      hop(1'b1, 1'b1);
      chk("rdata", hq, a ^ 8'h5a);
      chk("released", dvoe, 0);
      rdc("stat", mbp_pkg::OFF_STAT, 32'h0c);
      avs(1'b1, mbp_pkg::OFF_STAT, 32'h1f);
      tick(2);
      chk("irq off", irqoe, 0);
    end
    // masked flag must not reach the pin
    avs(1'b1, mbp_pkg::OFF_MASK, 32'h04);
    hop(1'b0, 1'b0);
    avs(1'b0, mbp_pkg::OFF_STATE, 32'h0);
    chk("latched desel", q32[15:8], a);
    rdc("stat desel", mbp_pkg::OFF_STAT, 32'h10);
    chk("masked", irqoe, 0);
    avs(1'b1, mbp_pkg::OFF_STAT, 32'h1f);
    key();
    rdc("key irq", mbp_pkg::OFF_STAT, 32'h01);
    chk("no pwr", pwr_n, 1);
    avs(1'b1, mbp_pkg::OFF_STAT, 32'h1f);
    avs(1'b1, mbp_pkg::OFF_CTRL, 32'h2);
    tick(2);
    chk("sw on", pwr_n, 0);
    avs(1'b1, mbp_pkg::OFF_CTRL, 32'h0);
    tick(2);
    chk("sw off", pwr_n, 1);
    sup <= 1'b0;
    tick(4);
    wake <= 1'b1;
    tick(1);
    wake <= 1'b0;
    tick(4);
    chk("wake pwr", pwr_n, 0);
    avs(1'b0, mbp_pkg::OFF_STAT, 32'h0);
    chk("wake flag", q32[1], 1);
    sup <= 1'b1;
    tick(4);
    avs(1'b1, mbp_pkg::OFF_CTRL, 32'h1);
    avs(1'b1, mbp_pkg::OFF_STAT, 32'h1f);
    chk("off again", pwr_n, 1);
    sup <= 1'b0;
    tick(4);
    key();
    chk("key pwr", pwr_n, 0);
    tick(8);
    results();
  end
endmodule
